// [tms_pkg.sv]
// Shared constants and types for the transceiver mode and calibration sequencer
package tms_pkg;
   // Clock and timing figures
   localparam int          CLK_PERIOD_NS  = 40;      // 25 MHz reference clock
   localparam int          CAL_TIME_NS    = 62500;   // Filter calibration window, 62.5 us
   localparam int          PA_LEAD_NS     = 5000;    // PA drops 5 us before RF goes
   localparam int          CNT_W          = 11;
   localparam int          TAIL_W         = 7;
   // Least times round up to whole cycles
   localparam logic [10:0] CAL_CYC        = 11'((CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [6:0]  PA_LEAD_CYC    = 7'((PA_LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   // Serial word layout: 14-bit data then 2-bit address, MSB first
   localparam int          WORD_W         = 16;
   localparam int          DATA_W         = 14;
   localparam int          ADDR_W         = 2;
   localparam int          DATA_LSB       = 2;
   localparam int          NUM_REGS       = 4;
   localparam logic [1:0]  MODULUS_ADDR   = 2'h1;    // Register holding the synthesizer word
   localparam logic [13:0] WORD_RESET     = 14'h0000;
   // Filter tuning
   localparam int          TUNE_W         = 8;
   localparam logic [7:0]  TUNE_MID       = 8'h80;   // Mid-range tuning at power-up
   localparam logic [10:0] REF_EDGES_EXP  = 11'h300; // Reference edges expected per window
   localparam logic [3:0]  CAL_ALL        = 4'hF;    // Discriminator, IF, RX LPF, TX LPF

   typedef enum logic [1:0]
   {
      MODE_STANDBY = 2'b00,
      MODE_RECEIVE = 2'b01,
      MODE_TRANSMIT = 2'b10
   } tms_mode_type;
endpackage : tms_pkg

// [tms_sequencer.sv]
// Mode decode, filter calibration and PA sequencing for a TDD FSK transceiver
//
// Functional notes
// - standby on chip select low; receive select: RX/TX
// - serial writes work and registers persist in standby
// - serial words are never checked, always accepted
// - power-up resets filter tuning to mid-range
// - calibrate 62.5 us after receive; data valid after
// - calibration updates four filter settings together
// - transmitter output disabled while synthesizer unlocked
// - synthesizer set by 14-bit integer/fraction word
// - mode pin transitions into receive or transmit trigger filter alignment
// - modulus register write outside standby starts new calibration
// - writes to other registers start no calibration
// - PA stays off 62.5 us after receive falls
// - receive mode delivers sliced NRZ data
// - 16-bit word, MSB first, data then address
// - shift while enable low; load on enable rise
// - PA high 62.5 us after RF, drops 5 us early
`timescale 1ns/1ps
`default_nettype none
module tms_sequencer
(
   input  wire logic         ref_clk_in,            // 25 MHz clock
   input  wire logic         rstn_in,               // Power-up reset, active low
   input  wire logic         chip_active_select_in, // Chip active pin
   input  wire logic         receive_select_in,     // Receive select pin
   input  wire logic         ser_clk_in,            // Serial bus clock pin
   input  wire logic         ser_data_in,           // Serial bus data pin
   input  wire logic         ser_en_in,             // Serial bus enable pin
   input  wire logic         reference_freq_in,     // Reference frequency, squared
   input  wire logic         pll_lock_in,           // Synthesizer lock detect
   input  wire logic         pa_interlock_in,       // Inhibit PA while unlocked
   input  wire logic         slicer_bit_in,         // Demodulated sliced bit
   output logic [1:0]        mode_out,              // Decoded mode
   output logic [13:0]       ctrl_word0_out,        // Register 0 contents
   output logic [13:0]       synth_word_out,        // Synthesizer N/P word
   output logic [13:0]       ctrl_word2_out,        // Register 2 contents
   output logic [13:0]       ctrl_word3_out,        // Register 3 contents
   output logic              cal_busy_out,          // Calibration running
   output logic [3:0]        cal_update_out,        // One-cycle filter update strobes
   output logic [7:0]        tune_value_out,        // Filter tuning value
   output logic              rx_data_valid_out,     // Receive data valid
   output logic              rx_data_out,           // Sliced NRZ receive data
   output logic              rf_tx_on_out,          // Transmit RF path enabled
   output logic              pa_enable_out          // External PA enable
);

   typedef struct packed {
      logic [1:0]                                cs_s;
      logic [1:0]                                rs_s;
      logic [1:0]                                dat_s;
      logic [1:0]                                lock_s;
      logic [1:0]                                slc_s;
      logic [2:0]                                sck_s;
      logic [2:0]                                sen_s;
      logic [2:0]                                ref_s;
      logic [1:0]                                il_s;
      tms_pkg::tms_mode_type                     mode;
      logic [tms_pkg::WORD_W-1:0]                shift;
      logic [tms_pkg::NUM_REGS-1:0][tms_pkg::DATA_W-1:0] words;
      logic                                      cal_busy;
      logic [tms_pkg::CNT_W-1:0]                 cal_cnt;
      logic [tms_pkg::CNT_W-1:0]                 ref_cnt;
      logic [tms_pkg::CNT_W-1:0]                 tx_cnt;
      logic [tms_pkg::TAIL_W-1:0]                tail_cnt;
      logic [tms_pkg::TUNE_W-1:0]                tune;
      logic [3:0]                                cal_upd;
      logic                                      rx_bit;
      logic                                      pa_en;
      logic                                      rf_on;
   } tms_state_type;

   tms_state_type st_r;
   tms_state_type st_nxt;
   logic          load_w;
   logic          mod_write_w;
   logic          cal_start_w;

   // Pin pair to mode; chip select low wins over receive select
   function automatic tms_pkg::tms_mode_type mode_of(input logic cs, input logic rs);
      if (!cs)
         return tms_pkg::MODE_STANDBY;
      else if (rs)
         return tms_pkg::MODE_RECEIVE;
      else
         return tms_pkg::MODE_TRANSMIT;
   endfunction : mode_of

   // Next-state logic
   always_comb
   begin
      st_nxt     = st_r;
      // Synchronisers; stage 0 feeds stage 1, and for clock, enable and reference stage 1 also feeds stage 2
      st_nxt.cs_s   = {st_r.cs_s[0], chip_active_select_in};
      st_nxt.rs_s   = {st_r.rs_s[0], receive_select_in};
      st_nxt.dat_s  = {st_r.dat_s[0], ser_data_in};
      st_nxt.lock_s = {st_r.lock_s[0], pll_lock_in};
      st_nxt.slc_s  = {st_r.slc_s[0], slicer_bit_in};
      st_nxt.sck_s  = {st_r.sck_s[1:0], ser_clk_in};
      st_nxt.sen_s  = {st_r.sen_s[1:0], ser_en_in};
      st_nxt.ref_s  = {st_r.ref_s[1:0], reference_freq_in};
      st_nxt.il_s   = {st_r.il_s[0], pa_interlock_in};
      st_nxt.cal_upd = 4'h0;

      st_nxt.mode = mode_of(st_r.cs_s[1], st_r.rs_s[1]);

      // Serial shifter runs in every mode, including standby
      if (!st_r.sen_s[1] && st_r.sck_s[1] && !st_r.sck_s[2])
         st_nxt.shift = {st_r.shift[tms_pkg::WORD_W-2:0], st_r.dat_s[1]};
      load_w      = st_r.sen_s[1] && !st_r.sen_s[2];
      mod_write_w = load_w && (st_r.shift[tms_pkg::ADDR_W-1:0] == tms_pkg::MODULUS_ADDR);
      // No parity or framing check; whatever is shifted is stored
      if (load_w)
         st_nxt.words[st_r.shift[tms_pkg::ADDR_W-1:0]] = st_r.shift[tms_pkg::WORD_W-1:tms_pkg::DATA_LSB];

      // Calibration starts on entry to an active mode or on a modulus write outside standby
      cal_start_w = ((st_nxt.mode != st_r.mode) && (st_nxt.mode != tms_pkg::MODE_STANDBY))
                 || (mod_write_w && (st_nxt.mode != tms_pkg::MODE_STANDBY));
      case (st_r.mode)
         tms_pkg::MODE_RECEIVE:  st_nxt.rx_bit = st_r.slc_s[1];
         default:                st_nxt.rx_bit = 1'b0;
      endcase
      if (cal_start_w)
      begin
         // A fresh trigger restarts the full window
         st_nxt.cal_busy = 1'b1;
         st_nxt.cal_cnt  = '0;
         st_nxt.ref_cnt  = '0;
      end
      else if (st_nxt.mode == tms_pkg::MODE_STANDBY)
         st_nxt.cal_busy = 1'b0;
      else if (st_r.cal_busy)
      begin
         // Window measured in clock cycles, reference edges counted inside it
         st_nxt.cal_cnt = st_r.cal_cnt + 11'h001;
         if (st_r.ref_s[1] && !st_r.ref_s[2])
            st_nxt.ref_cnt = st_r.ref_cnt + 11'h001;
         if (st_r.cal_cnt == tms_pkg::CAL_CYC - 11'h001)
         begin
            st_nxt.cal_busy = 1'b0;
            st_nxt.cal_upd  = tms_pkg::CAL_ALL;
            // One step per window keeps the filters from jumping on a noisy count
            if (st_r.ref_cnt > tms_pkg::REF_EDGES_EXP && st_r.tune != 8'hFF)
               st_nxt.tune = st_r.tune + 8'h01;
            else if (st_r.ref_cnt < tms_pkg::REF_EDGES_EXP && st_r.tune != 8'h00)
               st_nxt.tune = st_r.tune - 8'h01;
         end
      end

      // Transmit settle count from the fall of receive select
      if (st_nxt.mode != tms_pkg::MODE_TRANSMIT || st_r.mode != tms_pkg::MODE_TRANSMIT)
         st_nxt.tx_cnt = '0;
      else if (st_r.tx_cnt != tms_pkg::CAL_CYC)
         st_nxt.tx_cnt = st_r.tx_cnt + 11'h001;

      // PA follows the settled transmit slot, gated by lock when asked
      st_nxt.pa_en = (st_nxt.mode == tms_pkg::MODE_TRANSMIT) && (st_nxt.tx_cnt == tms_pkg::CAL_CYC)
                  && (!st_r.il_s[1] || st_r.lock_s[1]);

      // RF stays up PA_LEAD_CYC cycles after the PA drops, and never without lock
      if (st_nxt.mode == tms_pkg::MODE_TRANSMIT)
         st_nxt.tail_cnt = tms_pkg::PA_LEAD_CYC;
      else if (st_r.tail_cnt != 7'h00)
         st_nxt.tail_cnt = st_r.tail_cnt - 7'h01;
      // The registered count is read so the tail lasts the full PA_LEAD_CYC
      st_nxt.rf_on = st_r.lock_s[1] && ((st_nxt.mode == tms_pkg::MODE_TRANSMIT) || (st_r.tail_cnt != 7'h00));
   end

   // State register; tuning comes up mid-range
   always_ff @(posedge ref_clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         st_r      <= '0;
         st_r.tune <= tms_pkg::TUNE_MID;
         st_r.sen_s <= 3'h7;             // Idle enable level, so no false load edge after reset
      end
      else
         st_r <= st_nxt;
   end

   // Outputs straight from state
   assign mode_out          = st_r.mode;
   assign ctrl_word0_out    = st_r.words[0];
   assign synth_word_out    = st_r.words[tms_pkg::MODULUS_ADDR];
   assign ctrl_word2_out    = st_r.words[2];
   assign ctrl_word3_out    = st_r.words[3];
   assign cal_busy_out      = st_r.cal_busy;
   assign cal_update_out    = st_r.cal_upd;
   assign tune_value_out    = st_r.tune;
   assign rx_data_valid_out = (st_r.mode == tms_pkg::MODE_RECEIVE) && !st_r.cal_busy;
   assign rx_data_out       = st_r.rx_bit & rx_data_valid_out;
   assign rf_tx_on_out      = st_r.rf_on;
   assign pa_enable_out     = st_r.pa_en;

   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!rstn_in);

   chk_standby_decode: assert property (!st_r.cs_s[1] |=> st_r.mode == tms_pkg::MODE_STANDBY)
      else $error("standby not selected");
   chk_active_decode: assert property (st_r.cs_s[1] |=> st_r.mode == ($past(st_r.rs_s[1]) ?
      tms_pkg::MODE_RECEIVE : tms_pkg::MODE_TRANSMIT))
      else $error("active mode decode wrong");
   chk_load_stores: assert property (load_w |=> st_r.words[$past(st_r.shift[1:0])] == $past(st_r.shift[15:2]))
      else $error("serial word not loaded");
   chk_mod_restart: assert property (mod_write_w && st_r.mode != tms_pkg::MODE_STANDBY
      && st_nxt.mode != tms_pkg::MODE_STANDBY |=> st_r.cal_busy && st_r.cal_cnt == 11'h000)
      else $error("modulus write did not restart calibration");
   chk_other_no_cal: assert property (load_w && !mod_write_w && !st_r.cal_busy
      && st_nxt.mode == st_r.mode |=> !st_r.cal_busy)
      else $error("calibration from non-modulus write");
   chk_cal_length: assert property (st_r.cal_busy |-> st_r.cal_cnt < tms_pkg::CAL_CYC)
      else $error("calibration overran");
   chk_cal_strobe: assert property ($fell(st_r.cal_busy) && st_r.mode != tms_pkg::MODE_STANDBY
      |-> st_r.cal_upd == tms_pkg::CAL_ALL ##1 st_r.cal_upd == 4'h0)
      else $error("filter updates not strobed");
   chk_rx_valid: assert property ($rose(rx_data_valid_out) |-> st_r.cal_upd == tms_pkg::CAL_ALL)
      else $error("receive data valid before calibration done");
   chk_pa_settled: assert property (pa_enable_out |-> st_r.mode == tms_pkg::MODE_TRANSMIT
      && st_r.tx_cnt == tms_pkg::CAL_CYC)
      else $error("PA on before settle time");
   chk_pa_lock: assert property (pa_enable_out && $past(st_r.il_s[1]) |-> $past(st_r.lock_s[1]))
      else $error("PA on while unlocked");
   chk_rf_tail: assert property ($fell(pa_enable_out) && st_r.mode != tms_pkg::MODE_TRANSMIT
      && st_r.lock_s[1] && $past(st_r.lock_s[1]) |-> rf_tx_on_out)
      else $error("RF dropped with PA");

   cov_cal_done: cover property ($fell(st_r.cal_busy) && st_r.mode == tms_pkg::MODE_RECEIVE);
   cov_pa_on: cover property ($rose(pa_enable_out));
   cov_restart: cover property (st_r.cal_busy && mod_write_w);
endmodule : tms_sequencer
`default_nettype wire

// [tms_host_model.sv]
// Baseband controller model that drives the mode pins and the serial bus
`timescale 1ns/1ps
`default_nettype none
module tms_host_model
(
   input  wire logic clk_in,    // Reference clock
   output logic      cs_out,    // Chip active select
   output logic      rs_out,    // Receive select
   output logic      sclk_out,  // Serial clock, still outside frames
   output logic      sdata_out, // Serial data
   output logic      sen_out    // Serial enable
);
   // Idle bus: enable high, clock low, device in standby
   initial
   begin
      cs_out = 1'b0;
      rs_out = 1'b0;
      sclk_out = 1'b0;
      sdata_out = 1'b0;
      sen_out = 1'b1;
   end

   // Let clock edges pass
   task automatic ticks(input int n);
      repeat (n) @(posedge clk_in);
   endtask : ticks

   // Mode pins change at a rising edge
   task automatic pins(input logic cs, input logic rs);
      @(posedge clk_in);
      cs_out <= cs;
      rs_out <= rs;
      @(posedge clk_in);
   endtask : pins

   // Each clock phase lasts 3 cycles so the synchronisers always see it
   task automatic write_word(input logic [15:0] w);
      @(posedge clk_in);
      sen_out <= 1'b0;
      for (int i = 15; i >= 0; i--)
      begin
         sdata_out <= w[i];
         ticks(3);
         sclk_out <= 1'b1;
         ticks(3);
         sclk_out <= 1'b0;
      end
      ticks(3);
      sen_out <= 1'b1;
      sdata_out <= ~sdata_out; // Released line must not keep the last bit
      ticks(3);
   endtask : write_word
endmodule : tms_host_model
`default_nettype wire

// [tb.sv]
// Self-checking testbench for the mode and calibration sequencer
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic        ref_clk, rstn, ref_freq, lock, interlock, slicer;
   logic        cs, rs, sclk, sdata, sen, busy, rx_valid, rx_data, tx_on, pa;
   logic [1:0]  mode;
   logic [13:0] w0, w1, w2, w3;
   logic [3:0]  upd;
   logic [7:0]  tune;
   int          mismatches, check_count;

   tms_host_model host_u (.clk_in(ref_clk), .cs_out(cs), .rs_out(rs), .sclk_out(sclk),
      .sdata_out(sdata), .sen_out(sen));
   tms_sequencer dut_u (.ref_clk_in(ref_clk), .rstn_in(rstn), .chip_active_select_in(cs),
      .receive_select_in(rs), .ser_clk_in(sclk), .ser_data_in(sdata), .ser_en_in(sen),
      .reference_freq_in(ref_freq), .pll_lock_in(lock), .pa_interlock_in(interlock),
      .slicer_bit_in(slicer), .mode_out(mode), .ctrl_word0_out(w0), .synth_word_out(w1),
      .ctrl_word2_out(w2), .ctrl_word3_out(w3), .cal_busy_out(busy), .cal_update_out(upd),
      .tune_value_out(tune), .rx_data_valid_out(rx_valid), .rx_data_out(rx_data),
      .rf_tx_on_out(tx_on), .pa_enable_out(pa));

   // 25 MHz clock
   always #20 ref_clk = ~ref_clk;

   // Reference toggles each cycle: more edges per window than nominal
   always @(posedge ref_clk)
      ref_freq <= ~ref_freq;

   // Wait edges, then step past them so outputs have settled
   task automatic look(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : look

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp)
      begin
         mismatches++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic summarize;
      if (mismatches == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : summarize

   task automatic t_reset;
      chk(16'(mode), 16'h0000);
      chk(16'(tune), 16'h0080);
   endtask : t_reset

   // Count cycles from calibration start to the update strobe
   task automatic t_receive;
      int n;
      n = 0;
      host_u.pins(1'b1, 1'b1);
      while (busy !== 1'b1 && n < 10)
      begin
         look(1);
         n++;
      end
      chk(16'(mode), 16'h0001);
      n = 0;
      while (upd !== 4'hF && n < 2000)
      begin
         look(1);
         n++;
      end
      chk(16'(n), 16'd1563);
      chk(16'(tune), 16'h0081);
      chk(16'(rx_valid), 16'h0001);
      @(posedge ref_clk);
      slicer <= 1'b1;
      // Host trusts receive data only 325 us after chip select
      look(6560);
      chk(16'(rx_data), 16'h0001);
   endtask : t_receive

   task automatic t_serial;
      host_u.write_word({14'h1234, 2'h2});
      look(4);
      chk(16'(w2), 16'h1234);
      chk(16'(busy), 16'h0000);
      host_u.write_word({14'h2ABC, 2'h1});
      look(3);
      chk(16'(busy), 16'h0001);
      chk(16'(w1), 16'h2ABC);
   endtask : t_serial

   // Second modulus write mid-window pushes the window end out
   task automatic t_restart;
      look(200);
      host_u.write_word({14'h0F0F, 2'h1});
      look(1400);
      chk(16'(busy), 16'h0001);
      look(300);
      chk(16'(busy), 16'h0000);
      look(1425);
      chk(16'(rx_valid), 16'h0001);
   endtask : t_restart

   task automatic t_standby;
      host_u.pins(1'b0, 1'b0);
      look(5);
      chk(16'(mode), 16'h0000);
      host_u.pins(1'b0, 1'b1);
      look(5);
      chk(16'(mode), 16'h0000);
      host_u.write_word({14'h0155, 2'h3});
      look(4);
      chk(16'(w3), 16'h0155);
      chk(16'(w1), 16'h0F0F);
      chk(16'(rx_data), 16'h0000);
   endtask : t_standby

   task automatic t_transmit;
      host_u.pins(1'b1, 1'b1);
      look(1700);
      host_u.pins(1'b1, 1'b0);
      look(5);
      chk(16'(mode), 16'h0002);
      look(1500);
      chk(16'(pa), 16'h0000);
      look(100);
      chk(16'(pa), 16'h0001);
      @(posedge ref_clk);
      interlock <= 1'b0;
      lock <= 1'b0;
      look(6);
      chk(16'(pa), 16'h0001);
      chk(16'(tx_on), 16'h0000);
      @(posedge ref_clk);
      interlock <= 1'b1;
      look(6);
      chk(16'(pa), 16'h0000);
      @(posedge ref_clk);
      lock <= 1'b1;
      host_u.pins(1'b1, 1'b1);
      look(5);
      chk(16'(pa), 16'h0000);
      chk(16'(tx_on), 16'h0001);
      look(121);
      chk(16'(tx_on), 16'h0001);
      look(1);
      chk(16'(tx_on), 16'h0000);
      look(2875);
      chk(16'(rx_valid), 16'h0001);
   endtask : t_transmit

   // Whole run is near 18200 cycles; cut it off well beyond that
   initial
   begin
      repeat (30000) @(posedge ref_clk);
      mismatches++;
      summarize();
   end

   initial
   begin
      ref_clk = 1'b0;
      rstn = 1'b0;
      ref_freq = 1'b0;
      lock = 1'b1;
      interlock = 1'b1;
      slicer = 1'b0;
      mismatches = 0;
      check_count = 0;
      repeat (2) @(posedge ref_clk);
      rstn <= 1'b1;
      look(1);
      t_reset();
      t_receive();
      t_serial();
      t_restart();
      t_standby();
      t_transmit();
      summarize();
   end
endmodule : tb
`default_nettype wire
